// ==== logic/sfc_frame_ctrl.sv ====
// Frame-driven state control and serial output of a 14-bit SAR converter.
// Assumes chip-select and serial clock come from a host, asynchronous to clk;
// the analog conversion result arrives as a sampled code input.
`timescale 1ns/1ps
`default_nettype none
module sfc_frame_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [13:0] sample_code,
    output logic sdo_o,
    output logic sdo_oe,
    output logic sample_hold,
    output logic inputs_connected,
    output logic [2:0] state,
    output logic [13:0] offset_trim,
    output logic cal_done
);
    logic cs_lvl, cs_rise, cs_fall;
    logic sclk_lvl, sclk_rise, sclk_fall;

    sfc_pin_sync #(.INIT(1'b1)) u_cs (
        .clk(clk), .reset(reset), .pin(cs_n),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall)
    );
    sfc_pin_sync #(.INIT(1'b0)) u_sclk (
        .clk(clk), .reset(reset), .pin(sclk),
        .level(sclk_lvl), .rise(sclk_rise), .fall(sclk_fall)
    );

    sfc_pkg::sfc_state_t state_q, state_d;
    logic [sfc_pkg::EDGE_CNT_BITS-1:0] falls_q, falls_d;
    logic [13:0] shift_q, shift_d;
    logic [13:0] result_q, result_d;
    logic [13:0] held_q, held_d;
    logic [13:0] trim_q, trim_d;
    logic first_q, first_d;
    logic valid_q, valid_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic done_q, done_d;
    logic active;

    // Clock count that completes calibration, shorter in the first frame
    function automatic logic [sfc_pkg::EDGE_CNT_BITS-1:0] cal_clocks(input logic first);
        if (first)
            return 7'(sfc_pkg::PWRUP_CAL_CLOCKS);
        return 7'(sfc_pkg::NORMAL_CAL_CLOCKS);
    endfunction

    // Frame open between a falling and rising select edge
    assign active = ~cs_lvl;

    // Next state: frame, conversion steps and output shifting
    always_comb
    begin
        state_d = state_q;
        falls_d = falls_q;
        shift_d = shift_q;
        result_d = result_q;
        held_d = held_q;
        trim_d = trim_q;
        first_d = first_q;
        valid_d = valid_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        done_d = 1'b0;
        if (cs_fall)
        begin
            falls_d = '0;
            oe_d = 1'b1;
            sdo_d = 1'b0;
            // Previous result, or zeros in the first frame
            shift_d = first_q ? sfc_pkg::RESULT_RESET : result_q;
            if (!valid_q)
                shift_d = sfc_pkg::INVALID_CODE;
            if (state_q == sfc_pkg::SFC_ACQUIRE)
            begin
                held_d = sample_code;
                state_d = sfc_pkg::SFC_CONVERT;
            end
        end
        else if (active && sclk_fall)
        begin
            // Saturate the edge count past the longest frame
            if (falls_q != {sfc_pkg::EDGE_CNT_BITS{1'b1}})
                falls_d = falls_q + 7'd1;
            // Past the 18th fall the state waits for a calibration count;
            // a select rise before that count ends the frame in acquire
            if (falls_d == 7'(sfc_pkg::CONV_CLOCKS) && state_q == sfc_pkg::SFC_CONVERT)
            begin
                result_d = held_q - trim_q;
                valid_d = 1'b1;
                if (!first_q)
                    state_d = sfc_pkg::SFC_CALIB;
                else
                    state_d = sfc_pkg::SFC_CALIB;
            end
            if (state_q == sfc_pkg::SFC_CALIB
                && falls_d == cal_clocks(first_q))
            begin
                trim_d = held_q;
                done_d = 1'b1;
                first_d = 1'b0;
                state_d = sfc_pkg::SFC_ACQUIRE;
            end
        end
        else if (active && sclk_rise && falls_q != '0)
        begin
            // MSB first; zeros refill once all bits are out
            sdo_d = (first_q || state_q == sfc_pkg::SFC_CALIB && first_q) ? 1'b0 : shift_q[13];
            shift_d = {shift_q[12:0], 1'b0};
        end
        if (cs_rise)
        begin
            oe_d = 1'b0;
            sdo_d = 1'b0;
            // Select high means no fall is counted in this cycle, so the count is final
            if (falls_q < 7'(sfc_pkg::CONV_CLOCKS))
                valid_d = 1'b0;
            // Calibration cut short leaves trim untouched
            state_d = sfc_pkg::SFC_ACQUIRE;
            first_d = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= sfc_pkg::SFC_ACQUIRE;
            falls_q <= '0;
            shift_q <= sfc_pkg::RESULT_RESET;
            result_q <= sfc_pkg::RESULT_RESET;
            held_q <= sfc_pkg::RESULT_RESET;
            trim_q <= sfc_pkg::OFFSET_RESET;
            first_q <= 1'b1;
            valid_q <= 1'b1;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            falls_q <= falls_d;
            shift_q <= shift_d;
            result_q <= result_d;
            held_q <= held_d;
            trim_q <= trim_d;
            first_q <= first_d;
            valid_q <= valid_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            done_q <= done_d;
        end
    end

    // Outputs straight from flops; sample_hold and inputs_connected decoded from state_q
    assign sdo_o = sdo_q;
    assign sdo_oe = oe_q;
    assign state = state_q;
    assign offset_trim = trim_q;
    assign cal_done = done_q;
    assign sample_hold = (state_q != sfc_pkg::SFC_ACQUIRE);
    assign inputs_connected = (state_q == sfc_pkg::SFC_ACQUIRE);

    // Checks
    idle_release_a: assert property (@(posedge clk) disable iff (reset)
        cs_lvl && !cs_fall |-> ##1 !sdo_oe) else $error("output driven while idle");
    lead_zero_a: assert property (@(posedge clk) disable iff (reset)
        cs_fall |=> sdo_oe && !sdo_o) else $error("no leading zero");
    start_conv_a: assert property (@(posedge clk) disable iff (reset)
        cs_fall && state_q == sfc_pkg::SFC_ACQUIRE && !cs_rise |=> state_q == sfc_pkg::SFC_CONVERT)
        else $error("no conversion start");
    end_conv_a: assert property (@(posedge clk) disable iff (reset)
        state_q == sfc_pkg::SFC_CONVERT && falls_d == 7'(sfc_pkg::CONV_CLOCKS) && sclk_fall && !cs_rise
        |=> state_q != sfc_pkg::SFC_CONVERT) else $error("conversion did not end");
    frame_end_a: assert property (@(posedge clk) disable iff (reset)
        cs_rise |=> state_q == sfc_pkg::SFC_ACQUIRE) else $error("no acquire at frame end");
    first_zero_a: assert property (@(posedge clk) disable iff (reset)
        first_q && oe_q |-> !sdo_o) else $error("first frame not zero");
    short_bad_a: assert property (@(posedge clk) disable iff (reset)
        cs_rise && falls_q < 7'(sfc_pkg::CONV_CLOCKS) |=> !valid_q) else $error("short frame kept valid");
    trim_hold_a: assert property (@(posedge clk) disable iff (reset)
        !done_q |-> $stable(trim_q) or $past(done_d)) else $error("trim changed without calibration");
    msb_first_a: assert property (@(posedge clk) disable iff (reset)
        active && sclk_rise && falls_q == 7'd1 && !first_q && !cs_fall && !cs_rise
        |=> sdo_o == $past(shift_q[13])) else $error("wrong first bit");

    // Held sample, tail bits, invalid marking and calibration completion
    held_keep_a: assert property (@(posedge clk) disable iff (reset)
        sample_hold && $past(sample_hold) |-> $stable(held_q)) else $error("sample changed while held");
    tail_zero_a: assert property (@(posedge clk) disable iff (reset)
        active && sclk_rise && falls_q > 7'(sfc_pkg::RESULT_BITS) && !cs_fall && !cs_rise
        |=> !sdo_o) else $error("data after last bit");
    invalid_load_a: assert property (@(posedge clk) disable iff (reset)
        cs_fall && !valid_q |=> shift_q == sfc_pkg::INVALID_CODE) else $error("short frame result not marked");
    pwrup_cal_a: assert property (@(posedge clk) disable iff (reset)
        state_q == sfc_pkg::SFC_CALIB && first_q && active && sclk_fall && !cs_fall
        && falls_d == cal_clocks(1'b1)
        |=> cal_done && offset_trim == $past(held_q)) else $error("power-up calibration missed");
    norm_cal_a: assert property (@(posedge clk) disable iff (reset)
        state_q == sfc_pkg::SFC_CALIB && !first_q && active && sclk_fall && !cs_fall
        && falls_d == cal_clocks(1'b0)
        |=> cal_done && offset_trim == $past(held_q)) else $error("normal calibration missed");
    cal_end_a: assert property (@(posedge clk) disable iff (reset)
        done_q |-> state_q == sfc_pkg::SFC_ACQUIRE) else $error("no acquire after calibration");

    // Scenarios the frames are expected to reach
    cal_cov: cover property (@(posedge clk) done_q);
    conv_cov: cover property (@(posedge clk) state_q == sfc_pkg::SFC_CONVERT ##1 state_q == sfc_pkg::SFC_CALIB);
    short_cov: cover property (@(posedge clk) cs_rise && falls_q < 7'(sfc_pkg::CONV_CLOCKS));
    abort_cov: cover property (@(posedge clk) cs_rise && state_q == sfc_pkg::SFC_CALIB);
    invalid_cov: cover property (@(posedge clk) cs_fall && !valid_q);
endmodule
`default_nettype wire

// ==== logic/sfc_pin_sync.sv ====
// Two-flop synchroniser with edge detection on the synchronised level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sfc_pin_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First flop feeds only the second
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
            prev_q <= INIT;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges seen on the stable copy only
    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ==== logic/sfc_pkg.sv ====
// Constants for the converter frame and state control block.
// Assumes one 250 MHz system clock; serial clock and chip-select are sampled pins.
// Summary of operation
// - Acquire after power-up and calibration; conversion goes to calibration
// - Select falling edge samples, starts conversion
// - Serial clock drives conversion steps
// - Conversion ends itself after 18th clock
// - Frame shifts previous conversion result out
// - First frame after power-up outputs zeros
// - Leading zero driven at select fall
// - MSB on rise after first fall
// - Zeros after all 14 bits
// - Short frame gives invalid next result
// - Calibration corrects offset until power off
// - 24 clocks first frame start calibration
// - Early select rise aborts power-up calibration
// - 64 clocks normal frame start calibration
// - Rise between 18 and 64 aborts calibration
// - Frame spans select low; output released high
// - Result is 14-bit two's complement
package sfc_pkg;
    localparam int RESULT_BITS = 14;
    localparam int CONV_CLOCKS = 18;
    localparam int PWRUP_CAL_CLOCKS = 24;
    localparam int NORMAL_CAL_CLOCKS = 64;
    localparam int EDGE_CNT_BITS = 7;
    localparam logic [13:0] RESULT_RESET = 14'h0000;
    localparam logic [13:0] OFFSET_RESET = 14'h0000;
    localparam logic [13:0] CODE_MAX = 14'h1fff;
    localparam logic [13:0] CODE_MIN = 14'h2000;
    localparam logic [13:0] INVALID_CODE = 14'h3fff;
    typedef enum logic [2:0] {
        SFC_ACQUIRE = 3'b001,
        SFC_CONVERT = 3'b010,
        SFC_CALIB = 3'b100
    } sfc_state_t;
endpackage

// ==== verif/sfc_host_model.sv ====
// Host controller model: frames chip-select, makes the serial clock, reads serial data.
// Assumes a 4 ns clk; the serial clock is 12 clk per period (48 ns) and idles high.
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
    input wire logic clk,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic [2:0] state,
    input wire logic sample_hold,
    output logic cs_n,
    output logic sclk
);
    logic [63:0] rx;
    logic [2:0] st_first;
    logic hold_first;
    logic last_q;
    logic sdo_wire;
    // A released line shows the inverse of the last bit, so a floating read never passes by luck
    assign sdo_wire = sdo_oe ? sdo_o : ~last_q;
    always @(posedge clk)
    begin
        if (sdo_oe)
            last_q <= sdo_o;
    end
    // Idle frame levels at time zero
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        last_q = 1'b0;
        rx = '0;
        st_first = '0;
        hold_first = 1'b0;
    end
    // One frame of n clocks; each bit is read just before the falling edge
    task automatic frame(input int n);
        rx = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            rx = {rx[62:0], sdo_wire};
            if (i == 0)
            begin
                st_first = state;
                hold_first = sample_hold;
            end
            sclk <= 1'b0;
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            repeat (6) @(posedge clk);
        end
        cs_n <= 1'b1;
        repeat (60) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the frame and state control block.
// Assumes the host model drives the select and serial clock pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] sample_code = 14'h0000;
    logic cs_n, sclk, sdo_o, sdo_oe, sample_hold, inputs_connected, cal_done;
    logic [2:0] state;
    logic [13:0] offset_trim;
    int fail_count = 0;
    int tests_run = 0;
    int cal_pulses = 0;
    always #2 clk = ~clk;
    // Count calibration completions seen on the pulse output
    always @(posedge clk)
    begin
        if (cal_done === 1'b1)
            cal_pulses <= cal_pulses + 1;
    end
    sfc_frame_ctrl dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk), .sample_code(sample_code),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sample_hold(sample_hold), .inputs_connected(inputs_connected),
        .state(state), .offset_trim(offset_trim), .cal_done(cal_done));
    sfc_host_model host (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .state(state), .sample_hold(sample_hold),
        .cs_n(cs_n), .sclk(sclk));
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (exp !== got)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Power-up stands for reset; the pins settle before the release
    task automatic power_up();
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic run_frame(input int n, input logic [13:0] code, input int cals);
        int pulses_before;
        @(posedge clk);
        sample_code <= code;
        pulses_before = cal_pulses;
        host.frame(n);
        check("state", 64'(sfc_pkg::SFC_ACQUIRE), 64'(state));
        check("sdo_oe", 64'h0, 64'(sdo_oe));
        check("inputs_connected", 64'h1, 64'(inputs_connected));
        check("sample_hold", 64'h0, 64'(sample_hold));
        check("cal_done pulses", 64'(cals), 64'(cal_pulses - pulses_before));
    endtask
    task automatic test_powerup_cal();
        run_frame(24, 14'h0123, 1);
        check("cal frame data", 64'h0, host.rx);
        check("trim", 64'h0123, 64'(offset_trim));
    endtask
    task automatic test_conversion();
        run_frame(18, 14'h2123, 0);
        run_frame(18, 14'h1000, 0);
        check("state at first fall", 64'(sfc_pkg::SFC_CONVERT), 64'(host.st_first));
        check("hold at first fall", 64'h1, 64'(host.hold_first));
        check("frame data", 64'h2000 << 3, host.rx);
    endtask
    task automatic test_short_then_cal();
        run_frame(10, 14'h0005, 0);
        run_frame(64, 14'h0200, 1);
        check("long frame data", 64'h3fff << 49, host.rx);
        check("trim", 64'h0200, 64'(offset_trim));
    endtask
    task automatic test_cal_abort();
        run_frame(30, 14'h0400, 0);
        check("trim", 64'h0200, 64'(offset_trim));
        run_frame(18, 14'h0000, 0);
        check("frame data", 64'h0200 << 3, host.rx);
    endtask
    task automatic test_powerup_abort();
        power_up();
        run_frame(20, 14'h0777, 0);
        check("trim", 64'h0, 64'(offset_trim));
        check("first frame data", 64'h0, host.rx);
        run_frame(18, 14'h0000, 0);
        check("after abort data", 64'h0777 << 3, host.rx);
    endtask
    // Main sequence
    initial
    begin
        power_up();
        test_powerup_cal();
        test_conversion();
        test_short_then_cal();
        test_cal_abort();
        test_powerup_abort();
        summarize();
    end
    // Watchdog well beyond the roughly 3300 clk that the frames take
    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
